// ===== inc/dhsa_pkg.sv
// constants, encodings and register map of the dual host status/alert block
// assumes a single 50 MHz system clock and a plain register port
package dhsa_pkg;

   // ==========================================================
   // clock and timing
   localparam int unsigned SYS_CLK_KHZ = 50_000;
   // blink half period in milliseconds (plain default)
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * SYS_CLK_KHZ;
   localparam int unsigned BLINK_CNT_W = 24;

   // ==========================================================
   // register map, word index on reg_addr
   localparam logic [3:0] ADR_BUS = 4'h0;
   localparam logic [3:0] ADR_WORD = 4'h1;
   localparam logic [3:0] ADR_CML = 4'h2;
   localparam logic [3:0] ADR_RESP = 4'h3;
   localparam logic [3:0] ADR_IRQ_ST = 4'h4;
   localparam logic [3:0] ADR_IRQ_MSK = 4'h5;
   localparam int unsigned REG_W = 16;

   // ==========================================================
   // host port operations, presented by the port front end
   typedef enum logic [1:0] {
      OP_CMD = 2'b00,
      OP_CLR = 2'b01,
      OP_BAD = 2'b10,
      OP_TAKE = 2'b11
   } dhsa_op_e;

   // communication mode strap
   typedef enum logic [1:0] {
      MODE_ANALOG = 2'b00,
      MODE_I2C = 2'b01,
      MODE_RS485 = 2'b10
   } dhsa_mode_e;

   // ==========================================================
   // bus event field, three bits per port above its control bit
   typedef logic [2:0] dhsa_evt_t;
   localparam dhsa_evt_t EVT_NONE = 3'b000;
   localparam dhsa_evt_t EVT_TOOK = 3'b011;
   localparam dhsa_evt_t EVT_LOST = 3'b010;
   localparam dhsa_evt_t EVT_REJ = 3'b110;

   // ==========================================================
   // summary status word
   localparam int unsigned WORD_CML_BIT = 1;
   // bits that latch until cleared; the rest follow the live unit state
   localparam logic [15:0] WORD_STICKY = 16'hF0FA;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam int unsigned CML_BAD_BIT = 7;
   localparam logic [7:0] CML_ZERO = 8'h00;

   // ==========================================================
   // response settings and interrupt bits
   localparam logic [7:0] RESP_RST = 8'h00;
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_FLT = 0;
   localparam int unsigned IRQ_REJ = 1;
   localparam int unsigned IRQ_TAKE = 2;
   localparam int unsigned IRQ_BAD = 3;

   // width of the pin group passed through the synchroniser
   localparam int unsigned PIN_W = 33;

endpackage

// ===== inc/dhsa_blink_if.sv
// blink phase carrier between the blink generator and the top
// assumes both ends sit on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface dhsa_blink_if;
   logic phase;
   modport src (output phase);
   modport snk (input phase);
endinterface
`default_nettype wire

// ===== hw/dhsa_blink.sv
// free running blink generator for the front panel indicators
// assumes sys_clk and an asynchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module dhsa_blink
   import dhsa_pkg::*;
#(
   parameter int unsigned HALF_CYC = dhsa_pkg::BLINK_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   dhsa_blink_if.src bl
);
   import dhsa_pkg::*;

   // ==========================================================
   // half period counter
   localparam logic [BLINK_CNT_W-1:0] CNT_TOP =
      BLINK_CNT_W'(HALF_CYC - 1);
   localparam logic [BLINK_CNT_W-1:0] CNT_ONE = BLINK_CNT_W'(1);

   logic [BLINK_CNT_W-1:0] cnt_r;
   logic phase_r;
   wire logic wrap = (cnt_r == CNT_TOP);

   // phase toggles once per half period
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         phase_r <= 1'b0;
      end else begin
         cnt_r <= wrap ? '0 : cnt_r + CNT_ONE;
         phase_r <= phase_r ^ wrap;
      end
   end

   assign bl.phase = phase_r;

endmodule
`default_nettype wire

// ===== hw/dhsa_top.sv
// dual host port status, alert and indicator logic
// assumes port front ends present decoded operations on the link clock,
// unit status pins are asynchronous, the register port is on sys_clk
//
// Contract
// R1: input led is steady when input is ok and blinks when out of limits; output led is steady when output good and blinks on overload.
// R2: temperature led is steady on over-temperature warning, but blinks for a service request in two-wire host mode.
// R3: fault led is steady on a unit fault and blinks on lost host link in multidrop serial mode.
// R4: a host reads status before clear-faults because clearing drops latched data.
// R5: only the controlling port clears status, and its clear never drops the other port's alert; here it clears fault and bad-command alerts of both.
// R6: power supply alarms never set bus event bits.
// R7: a command from the port not in control is rejected, recorded as that port's reject bits and raises its alert.
// R8: when idle the bus event register reads 0x01 with port 0 in control and 0x10 with port 1.
// R9: a control takeover is recorded in the bus event register and raises both alerts.
// R10: clear-faults from a port removes only that port's event bits and drops its alert; here a port not in control keeps fault and bad-command alerts.
// R11: a port's alert stays while that port has uncleared bus events.
// R12: a unit fault is latched in the summary word and raises both alerts without touching bus events.
// R13: controller clear-faults after the fault left returns the word to zero and drops the alerts.
// R14: an invalid command from the controller sets word 0x0002 and comm error 0x80 and raises its alert.
// R15: fault, warning, shutdown, isolation test and comm error bits latch until clear-faults.
// R16: response settings change only by an explicit write, never by clear-faults.
// R17: a fault still present after clear-faults reasserts; operational bits follow live state.
`timescale 1ns/1ps
`default_nettype none
module dhsa_top #(
   parameter int unsigned BLINK_HALF_CYC = dhsa_pkg::BLINK_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [dhsa_pkg::REG_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dhsa_pkg::REG_W-1:0] reg_rdata,
   output logic irq,
   input wire logic link_clk,
   input wire logic p0_cmd_vld,
   input wire logic [1:0] p0_cmd_op,
   input wire logic p1_cmd_vld,
   input wire logic [1:0] p1_cmd_op,
   input wire logic [15:0] unit_stat,
   input wire logic unit_fault,
   input wire logic in_ok,
   input wire logic in_present,
   input wire logic out_ok,
   input wire logic overload,
   input wire logic ot_warn,
   input wire logic svc_req,
   input wire logic comm_lost,
   input wire logic [1:0] comm_mode,
   output logic alert_0_o,
   output logic alert_0_oe,
   output logic alert_1_o,
   output logic alert_1_oe,
   output logic led_in,
   output logic led_out,
   output logic led_temp,
   output logic led_fault
);
   import dhsa_pkg::*;

   // ==========================================================
   // pin synchroniser: stage one feeds only stage two
   logic [PIN_W-1:0] pin_s1_r;
   logic [PIN_W-1:0] pin_s2_r;
   logic lclk_d_r;
   wire logic [PIN_W-1:0] pin_raw = {link_clk, p0_cmd_vld, p0_cmd_op,
      p1_cmd_vld, p1_cmd_op, unit_stat, unit_fault, in_ok, in_present,
      out_ok, overload, ot_warn, svc_req, comm_lost, comm_mode};

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         lclk_d_r <= 1'b0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         lclk_d_r <= pin_s2_r[PIN_W-1];
      end
   end

   // synchronised pin views
   wire logic lclk_s = pin_s2_r[PIN_W-1];
   wire logic v0_s = pin_s2_r[PIN_W-2];
   wire logic [1:0] op0_s = pin_s2_r[PIN_W-3 -: 2];
   wire logic v1_s = pin_s2_r[PIN_W-5];
   wire logic [1:0] op1_s = pin_s2_r[PIN_W-6 -: 2];
   wire logic [15:0] live_s = pin_s2_r[PIN_W-8 -: 16];
   wire logic ufault_s = pin_s2_r[9];
   wire logic in_ok_s = pin_s2_r[8];
   wire logic in_pres_s = pin_s2_r[7];
   wire logic out_ok_s = pin_s2_r[6];
   wire logic ovl_s = pin_s2_r[5];
   wire logic otw_s = pin_s2_r[4];
   wire logic svc_s = pin_s2_r[3];
   wire logic clost_s = pin_s2_r[2];
   wire logic [1:0] mode_s = pin_s2_r[1:0];

   // ops are sampled on the link clock rising edge found here
   wire logic lnk_rise = lclk_s & ~lclk_d_r;
   wire logic ev0 = lnk_rise & v0_s;
   wire logic ev1 = lnk_rise & v1_s;

   // ==========================================================
   // control and bus event state
   logic ctrl_r;
   dhsa_evt_t evt0_r;
   dhsa_evt_t evt1_r;
   logic [15:0] word_lat_r;
   logic [7:0] cml_r;
   logic fpend_r;
   logic [1:0] bpend_r;
   logic [7:0] resp_r;
   logic [IRQ_W-1:0] irq_st_r;
   logic [IRQ_W-1:0] irq_msk_r;

   // next event field: own clear wipes it, new events win over the clear
   function automatic dhsa_evt_t evt_next(input dhsa_evt_t cur,
      input logic clr, input logic rej, input logic took,
      input logic lost);
      dhsa_evt_t v;
      v = clr ? EVT_NONE : cur;
      v = v | (rej ? EVT_REJ : EVT_NONE);
      v = v | (took ? EVT_TOOK : EVT_NONE);
      v = v | (lost ? EVT_LOST : EVT_NONE);
      return v;
   endfunction

   // operation decode per port
   wire logic ctl0 = (ctrl_r == 1'b0);
   wire logic ctl1 = (ctrl_r == 1'b1);
   wire logic take0 = ev0 & (op0_s == OP_TAKE) & ~ctl0;
   wire logic take1 = ev1 & (op1_s == OP_TAKE) & ~ctl1 & ~take0;
   wire logic rej0 = ev0 & ~ctl0 & ((op0_s == OP_CMD) | (op0_s == OP_BAD));
   wire logic rej1 = ev1 & ~ctl1 & ((op1_s == OP_CMD) | (op1_s == OP_BAD));
   wire logic clr0 = ev0 & (op0_s == OP_CLR);
   wire logic clr1 = ev1 & (op1_s == OP_CLR);
   wire logic bad0 = ev0 & (op0_s == OP_BAD) & ctl0;
   wire logic bad1 = ev1 & (op1_s == OP_BAD) & ctl1;
   wire logic clr_ctl = (clr0 & ctl0) | (clr1 & ctl1); // R5

   // bus events come only from host ops, never from unit alarms
   wire dhsa_evt_t evt0_nxt =
      evt_next(evt0_r, clr0, rej0, take0, take1); // R6 R7 R9 R10
   wire dhsa_evt_t evt1_nxt =
      evt_next(evt1_r, clr1, rej1, take1, take0); // R6 R7 R9 R10
   wire logic ctrl_nxt = take1 ? 1'b1 : (take0 ? 1'b0 : ctrl_r);
   // control bits sit in the low bit of each nibble
   wire logic [7:0] bus_view = {evt1_r, ctl1, evt0_r, ctl0}; // R8

   // summary word: sticky bits latch, a clear restarts from live state
   wire logic [15:0] live_sticky = live_s & WORD_STICKY;
   wire logic [15:0] word_nxt =
      (clr_ctl ? WORD_ZERO : word_lat_r) | live_sticky; // R15 R17
   wire logic new_flt = |(live_sticky & ~word_lat_r); // R12
   wire logic fpend_nxt =
      clr_ctl ? |live_sticky : (fpend_r | new_flt); // R13 R17
   wire logic [7:0] cml_bad = CML_ZERO | (8'h01 << CML_BAD_BIT);
   wire logic [7:0] cml_nxt =
      (clr_ctl ? CML_ZERO : cml_r) | ((bad0 | bad1) ? cml_bad : CML_ZERO); // R14
   wire logic [15:0] cml_word = WORD_ZERO | (16'(|cml_r) << WORD_CML_BIT);
   // operational bits are not held; they read straight from live state
   wire logic [15:0] word_view =
      word_lat_r | (live_s & ~WORD_STICKY) | cml_word; // R17
   // bad-command alert belongs to the issuing port only
   wire logic [1:0] bpend_nxt =
      (clr_ctl ? 2'b00 : bpend_r) | {bad1, bad0}; // R14

   // alerts: own bus events, shared unit fault, own bad command
   wire logic al0_nxt = (|evt0_nxt) | fpend_nxt | bpend_nxt[0]; // R5 R11 R12
   wire logic al1_nxt = (|evt1_nxt) | fpend_nxt | bpend_nxt[1]; // R5 R11 R12

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= 1'b0;
         evt0_r <= EVT_NONE;
         evt1_r <= EVT_NONE;
         word_lat_r <= WORD_ZERO;
         cml_r <= CML_ZERO;
         fpend_r <= 1'b0;
         bpend_r <= 2'b00;
         alert_0_oe <= 1'b0;
         alert_1_oe <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         evt0_r <= evt0_nxt;
         evt1_r <= evt1_nxt;
         word_lat_r <= word_nxt;
         cml_r <= cml_nxt;
         fpend_r <= fpend_nxt;
         bpend_r <= bpend_nxt;
         alert_0_oe <= al0_nxt;
         alert_1_oe <= al1_nxt;
      end
   end

   // open drain alerts only ever pull low; kept in flops for clean pins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         alert_0_o <= 1'b0;
         alert_1_o <= 1'b0;
      end else begin
         alert_0_o <= 1'b0;
         alert_1_o <= 1'b0;
      end
   end

   // ==========================================================
   // register port and interrupts
   wire logic wr_resp = reg_wr & (reg_addr == ADR_RESP);
   wire logic wr_ist = reg_wr & (reg_addr == ADR_IRQ_ST);
   wire logic wr_msk = reg_wr & (reg_addr == ADR_IRQ_MSK);
   wire logic [IRQ_W-1:0] irq_ev = {bad0 | bad1, take0 | take1,
      rej0 | rej1, new_flt};
   // write one clears, a fresh event in the same cycle survives
   wire logic [IRQ_W-1:0] irq_st_nxt =
      (irq_st_r & ~(wr_ist ? reg_wdata[IRQ_W-1:0] : '0)) | irq_ev;
   logic [REG_W-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      unique case (reg_addr)
         ADR_BUS: rd_mux = {8'h00, bus_view};
         ADR_WORD: rd_mux = word_view;
         ADR_CML: rd_mux = {8'h00, cml_r};
         ADR_RESP: rd_mux = {8'h00, resp_r};
         ADR_IRQ_ST: rd_mux = {12'h000, irq_st_r};
         ADR_IRQ_MSK: rd_mux = {12'h000, irq_msk_r};
         default: rd_mux = '0; // unmapped reads zero
      endcase
   end

   // response settings only move on an explicit write
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         resp_r <= RESP_RST;
         irq_msk_r <= '0;
         irq_st_r <= '0;
         irq <= 1'b0;
         reg_rdata <= '0;
      end else begin
         resp_r <= wr_resp ? reg_wdata[7:0] : resp_r; // R16
         irq_msk_r <= wr_msk ? reg_wdata[IRQ_W-1:0] : irq_msk_r;
         irq_st_r <= irq_st_nxt;
         irq <= |(irq_st_nxt & irq_msk_r);
         reg_rdata <= reg_rd ? rd_mux : '0;
      end
   end

   // ==========================================================
   // front panel indicators
   dhsa_blink_if bl_if ();
   dhsa_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .bl(bl_if)
   );
   wire logic blk = bl_if.phase;
   wire logic mode_i2c = (mode_s == MODE_I2C);
   wire logic mode_485 = (mode_s == MODE_RS485);
   wire logic in_nxt = in_ok_s | (in_pres_s & blk); // R1
   wire logic out_nxt = ovl_s ? blk : out_ok_s; // R1
   wire logic temp_nxt = (mode_i2c & svc_s) ? blk : otw_s; // R2
   wire logic flt_nxt = ufault_s | (mode_485 & clost_s & blk); // R3

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         led_in <= 1'b0;
         led_out <= 1'b0;
         led_temp <= 1'b0;
         led_fault <= 1'b0;
      end else begin
         led_in <= in_nxt;
         led_out <= out_nxt;
         led_temp <= temp_nxt;
         led_fault <= flt_nxt;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_take1_done;
      ((evt1_r & EVT_TOOK) == EVT_TOOK) && ((evt0_r & EVT_LOST) == EVT_LOST)
         && ctl1 && alert_0_oe && alert_1_oe;
   endsequence
   sequence s_clean_word;
      (word_lat_r == WORD_ZERO) && !fpend_r && (cml_r == CML_ZERO);
   endsequence

   a_led_input: assert property (in_ok_s |=> led_in) // R1
      else $error("input led dark while input ok");
   a_led_temp: assert property (otw_s && !svc_s |=> led_temp) // R2
      else $error("temperature led dark on warning");
   a_led_fault: assert property (ufault_s |=> led_fault) // R3
      else $error("fault led dark on unit fault");
   a_ctl_clear: assert property (clr0 && ctl1 && !clr1 |=> // R5
      (word_lat_r & $past(word_lat_r)) == $past(word_lat_r))
      else $error("non controlling port cleared status word");
   a_bus_alarm: assert property (!ev0 && !ev1 |=> $stable(bus_view)) // R6
      else $error("bus events moved without a host op");
   a_reject_rec: assert property (rej1 |=> // R7
      ((evt1_r & EVT_REJ) == EVT_REJ) && alert_1_oe)
      else $error("rejected command not recorded");
   a_idle_bus: assert property (evt0_r == EVT_NONE && evt1_r == EVT_NONE // R8
      |-> bus_view == (ctl1 ? 8'h10 : 8'h01))
      else $error("idle bus value wrong");
   a_take_over: assert property (take1 |=> s_take1_done) // R9
      else $error("takeover not recorded or alerts missing");
   a_own_clear: assert property (clr1 && !ev0 |=> // R10
      evt1_r == EVT_NONE && $stable(evt0_r))
      else $error("clear touched the other port's events");
   a_alert_hold: assert property (|evt0_r |-> alert_0_oe) // R11
      else $error("alert dropped with events pending");
   a_fault_both: assert property (new_flt && !ev0 && !ev1 |=> // R12
      alert_0_oe && alert_1_oe && $stable(bus_view))
      else $error("unit fault did not raise both alerts");
   a_clear_word: assert property ( // R13
      clr_ctl && live_sticky == WORD_ZERO |=> s_clean_word)
      else $error("clear faults left status behind");
   a_bad_cmd: assert property (bad1 && !clr0 |=> // R14
      cml_r[CML_BAD_BIT] && word_view[WORD_CML_BIT] && alert_1_oe)
      else $error("invalid command not reported");
   a_resp_keep: assert property (clr_ctl && !wr_resp |=> $stable(resp_r)) // R16
      else $error("response settings moved on clear");
   a_fault_back: assert property (clr_ctl && |live_sticky |=> // R17
      fpend_r && (word_lat_r & $past(live_sticky)) == $past(live_sticky))
      else $error("persisting fault not reasserted");

endmodule
`default_nettype wire

// ===== bench/dhsa_host_model.sv
// two redundant host controllers as seen through their port front ends
// assumes the block samples link_clk with its own clock and finds edges
`timescale 1ns/1ps
`default_nettype none
module dhsa_host_model (
   output logic link_clk,
   output logic p0_cmd_vld,
   output logic [1:0] p0_cmd_op,
   output logic p1_cmd_vld,
   output logic [1:0] p1_cmd_op
);
   import dhsa_pkg::*;

   // idle: link clock low and still, no op valid
   initial begin
      link_clk = 1'b0;
      p0_cmd_vld = 1'b0;
      p1_cmd_vld = 1'b0;
      p0_cmd_op = 2'b00;
      p1_cmd_op = 2'b00;
   end

   // ==========================================================
   // one op per frame; the op is held across the single rising link edge,
   // lag_ns lets a slow controller dawdle before the edge
   task automatic send(input int port, input dhsa_op_e o, input int lag_ns);
      if (port == 0) begin
         p0_cmd_vld = 1'b1;
         p0_cmd_op = o;
      end else begin
         p1_cmd_vld = 1'b1;
         p1_cmd_op = o;
      end
      #(40 + lag_ns);
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
      #40;
      // released op lines show the inverse so a stale op never looks valid
      if (port == 0) begin
         p0_cmd_vld = 1'b0;
         p0_cmd_op = ~o;
      end else begin
         p1_cmd_vld = 1'b0;
         p1_cmd_op = ~o;
      end
   endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the dual host status, alert and indicator block
// assumes the host model drives the link side and the bench everything else
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dhsa_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [15:0] unit_stat = 16'h0000;
   logic [7:0] ind = 8'h00;
   logic [1:0] comm_mode = 2'b00;
   logic [1:0] p0_op, p1_op;
   logic irq, link_clk, p0_vld, p1_vld, a0_o, a0_oe, a1_o, a1_oe;
   logic [3:0] leds;
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;

   // ==========================================================
   // clock, design and host model
   always #10 sys_clk = ~sys_clk;

   // blink half period cut to 4 cycles so a blink shows in a short window
   dhsa_top #(.BLINK_HALF_CYC(4)) u_dhsa_top (
      .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .link_clk(link_clk),
      .p0_cmd_vld(p0_vld), .p0_cmd_op(p0_op), .p1_cmd_vld(p1_vld),
      .p1_cmd_op(p1_op), .unit_stat(unit_stat), .unit_fault(ind[6]),
      .in_ok(ind[0]), .in_present(ind[1]), .out_ok(ind[2]),
      .overload(ind[3]), .ot_warn(ind[4]), .svc_req(ind[5]),
      .comm_lost(ind[7]), .comm_mode(comm_mode), .alert_0_o(a0_o),
      .alert_0_oe(a0_oe), .alert_1_o(a1_o), .alert_1_oe(a1_oe),
      .led_in(leds[0]), .led_out(leds[1]), .led_temp(leds[2]),
      .led_fault(leds[3]));

   dhsa_host_model u_dhsa_host_model (
      .link_clk(link_clk), .p0_cmd_vld(p0_vld), .p0_cmd_op(p0_op),
      .p1_cmd_vld(p1_vld), .p1_cmd_op(p1_op));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time,
            what, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp, "register read");
   endtask
   task automatic op(input int port, input dhsa_op_e o);
      u_dhsa_host_model.send(port, o, 0);
      tick(2);
   endtask
   task automatic stat(input logic [15:0] bus, input logic [15:0] word,
         input logic [15:0] cml, input logic al1, input logic al0);
      rd_chk(ADR_BUS, bus);
      rd_chk(ADR_WORD, word);
      rd_chk(ADR_CML, cml);
      check({15'h0, a1_oe}, {15'h0, al1}, "alert 1");
      check({15'h0, a0_oe}, {15'h0, al0}, "alert 0");
   endtask
   task automatic set_unit(input logic [15:0] v);
      @(posedge sys_clk) unit_stat <= v;
      tick(5);
   endtask
   // classify an indicator over 16 cycles: 0 off, 1 on, 2 blinking
   task automatic led_case(input logic [7:0] p, input logic [1:0] m,
         input int i, input int want);
      int ones;
      int tog;
      logic last;
      @(posedge sys_clk) ind <= p;
      comm_mode <= m;
      tick(5);
      ones = 0;
      tog = 0;
      last = leds[i];
      repeat (16) begin
         @(posedge sys_clk);
         #1;
         ones += (leds[i] === 1'b1);
         tog += (leds[i] !== last);
         last = leds[i];
      end
      check((ones == 0) ? 16'h0 : (ones == 16) ? 16'h1 : (tog >= 2) ?
         16'h2 : 16'h3, want[15:0], "indicator look");
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      stat(16'h0001, 16'h0000, 16'h0000, 1'b0, 1'b0);
      rd_chk(ADR_RESP, 16'h0000);
      rd_chk(ADR_IRQ_MSK, 16'h0000);
      rd_chk(4'hF, 16'h0000);
      check({14'h0, a1_o, a0_o}, 16'h0000, "alert drive level");
      $display("test reset done");
   endtask
   task automatic t_reject();
      op(0, OP_CMD);
      stat(16'h0001, 16'h0000, 16'h0000, 1'b0, 1'b0);
      op(1, OP_CMD);
      stat(16'h00C1, 16'h0000, 16'h0000, 1'b1, 1'b0);
      op(1, OP_CLR);
      stat(16'h0001, 16'h0000, 16'h0000, 1'b0, 1'b0);
      $display("test reject done");
   endtask
   task automatic t_fault();
      set_unit(16'h0008);
      stat(16'h0001, 16'h0008, 16'h0000, 1'b1, 1'b1);
      op(1, OP_CLR);
      stat(16'h0001, 16'h0008, 16'h0000, 1'b1, 1'b1);
      op(1, OP_TAKE);
      set_unit(16'h0000);
      stat(16'h0074, 16'h0008, 16'h0000, 1'b1, 1'b1);
      op(1, OP_CLR);
      stat(16'h0014, 16'h0000, 16'h0000, 1'b0, 1'b1);
      op(0, OP_CLR);
      stat(16'h0010, 16'h0000, 16'h0000, 1'b0, 1'b0);
      $display("test fault done");
   endtask
   task automatic t_take();
      op(0, OP_TAKE);
      stat(16'h0047, 16'h0000, 16'h0000, 1'b1, 1'b1);
      op(0, OP_CLR);
      stat(16'h0041, 16'h0000, 16'h0000, 1'b1, 1'b0);
      op(1, OP_CLR);
      op(0, OP_TAKE);
      stat(16'h0001, 16'h0000, 16'h0000, 1'b0, 1'b0);
      op(1, OP_TAKE);
      op(1, OP_CLR);
      op(0, OP_CLR);
      op(0, OP_CMD);
      stat(16'h001C, 16'h0000, 16'h0000, 1'b0, 1'b1);
      op(0, OP_CLR);
      op(1, OP_BAD);
      stat(16'h0010, 16'h0002, 16'h0080, 1'b1, 1'b0);
      op(1, OP_CLR);
      stat(16'h0010, 16'h0000, 16'h0000, 1'b0, 1'b0);
      $display("test takeover done");
   endtask
   task automatic t_persist();
      set_unit(16'h0009);
      op(1, OP_CLR);
      stat(16'h0010, 16'h0009, 16'h0000, 1'b1, 1'b1);
      set_unit(16'h0000);
      rd_chk(ADR_WORD, 16'h0008);
      op(0, OP_CLR);
      rd_chk(ADR_WORD, 16'h0008);
      op(1, OP_CLR);
      stat(16'h0010, 16'h0000, 16'h0000, 1'b0, 1'b0);
      $display("test persist done");
   endtask
   task automatic t_regs();
      wr(ADR_RESP, 16'h005A);
      wr(ADR_BUS, 16'h00FF);
      op(1, OP_CLR);
      rd_chk(ADR_RESP, 16'h005A);
      rd_chk(ADR_BUS, 16'h0010);
      rd_chk(ADR_IRQ_ST, 16'h000F);
      wr(ADR_IRQ_ST, 16'h000F);
      wr(ADR_IRQ_MSK, 16'h0002);
      rd_chk(ADR_IRQ_ST, 16'h0000);
      // a slow controller still gets its rejected command recorded
      u_dhsa_host_model.send(0, OP_CMD, 300);
      tick(2);
      rd_chk(ADR_IRQ_ST, 16'h0002);
      check({15'h0, irq}, 16'h0001, "irq raised");
      wr(ADR_IRQ_MSK, 16'h0000);
      tick(2);
      check({15'h0, irq}, 16'h0000, "irq masked");
      wr(ADR_IRQ_MSK, 16'h0002);
      wr(ADR_IRQ_ST, 16'h0002);
      tick(2);
      check({15'h0, irq}, 16'h0000, "irq cleared");
      op(0, OP_CLR);
      $display("test registers done");
   endtask
   task automatic t_leds();
      led_case(8'h01, 2'b00, 0, 1);
      led_case(8'h02, 2'b00, 0, 2);
      led_case(8'h04, 2'b00, 1, 1);
      led_case(8'h0C, 2'b00, 1, 2);
      led_case(8'h10, 2'b10, 2, 1);
      led_case(8'h30, 2'b01, 2, 2);
      led_case(8'h30, 2'b00, 2, 1);
      led_case(8'h40, 2'b01, 3, 1);
      led_case(8'h80, 2'b10, 3, 2);
      led_case(8'hC8, 2'b01, 3, 1);
      rd_chk(ADR_BUS, 16'h0010);
      $display("test indicators done");
   endtask

   // ==========================================================
   // run control
   task automatic complete_run();
      $display("compared %0d, mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // the whole sequence needs well under a thousand cycles; the ceiling is ample
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   initial begin
      tick(2);
      rst_b <= 1'b1;
      tick(2);
      t_reset();
      t_reject();
      t_fault();
      t_take();
      t_persist();
      t_regs();
      t_leds();
      complete_run();
   end
endmodule
`default_nettype wire
